/* File: design/aprt_defs.vh */
// register offsets, field positions, reset values and codes for the audio port pin routing block
`ifndef APRT_DEFS_VH
`define APRT_DEFS_VH
// register indices (printed offsets are not all multiples of four; byte address = index * 4)
`define APRT_IDX_ROUTING_TWO 8'h11
`define APRT_IDX_ROUTING_THREE 8'h12
`define APRT_IDX_ROUTING_FIVE 8'h14
`define APRT_IDX_PORT_CONFIG_ZERO 8'h18
`define APRT_IDX_PORT_CONFIG_ONE 8'h19
`define APRT_IDX_SOFT_CONTROL 8'h1c
`define APRT_IDX_STATUS 8'h1d
// reset values
`define APRT_RST_ROUTING_TWO 8'h80
`define APRT_RST_ROUTING_THREE 8'h00
`define APRT_RST_ROUTING_FIVE 8'h00
`define APRT_RST_PORT_CONFIG_ZERO 8'h40
`define APRT_RST_PORT_CONFIG_ONE 8'h00
`define APRT_RST_SOFT_CONTROL 8'h00
// writable bit masks (reserved read-only bits stay zero)
`define APRT_WMASK_ROUTING_TWO 8'hfe
`define APRT_WMASK_ROUTING_THREE 8'hfc
`define APRT_WMASK_ROUTING_FIVE 8'hff
`define APRT_WMASK_PORT_CONFIG_ZERO 8'hff
`define APRT_WMASK_PORT_CONFIG_ONE 8'hfe
`define APRT_WMASK_SOFT_CONTROL 8'h01
// field positions
`define APRT_BIT_PRIMARY_INPUT_ACCEPT 7
`define APRT_SYNC_SRC_HI 6
`define APRT_SYNC_SRC_LO 4
`define APRT_BCLK_SRC_HI 3
`define APRT_BCLK_SRC_LO 1
`define APRT_IN1_SRC_HI 7
`define APRT_IN1_SRC_LO 5
`define APRT_IN2_SRC_HI 4
`define APRT_IN2_SRC_LO 2
`define APRT_PD_SRC_HI 3
`define APRT_PD_SRC_LO 2
`define APRT_BIT_POWER_LIMITER 1
`define APRT_BIT_GAIN_FEATURE 0
`define APRT_BIT_PRIMARY_OFF 7
`define APRT_BIT_SECONDARY_OFF 6
`define APRT_BIT_FOLLOWS_PRIMARY 5
`define APRT_DAISY_EN_HI 4
`define APRT_DAISY_EN_LO 3
`define APRT_DAISY_IN_HI 2
`define APRT_DAISY_IN_LO 0
`define APRT_BIT_DAISY_DIR 3
`define APRT_BIT_SOFT_POWERDOWN 0
// source selection codes
`define APRT_SRC_OFF 3'h0
`define APRT_SRC_PIN_ONE 3'h1
`define APRT_SRC_PIN_TWO 3'h2
`define APRT_SRC_INPUT_ONLY 3'h3
`define APRT_SRC_DATA_OUT_PIN 3'h4
`define APRT_SRC_PRIMARY 3'h5
// daisy chain modes
`define APRT_DAISY_OFF 2'h0
`define APRT_DAISY_PRIMARY 2'h1
`define APRT_DAISY_SECONDARY 2'h2
`endif

/* File: design/aprt_pin_routing.v */
// audio port pin routing: apb register file and secondary port / daisy / power-down muxing
`include "aprt_defs.vh"

// Function
// - primary data input accept bit, resets one
// - secondary sync source select, five picks primary
// - secondary bit clock source select field
// - secondary first data input source select
// - secondary second data input, same encoding
// - power-down pin select field, zero disables
// - converter off if pin OR soft request
// - pin one drives power limiter when set
// - pin one drives gain feature when set
// - primary port off bit, resets enabled
// - secondary port off bit, resets disabled
// - secondary takes primary settings when ganged
// - daisy enable field picks chained port
// - daisy chain input pin select field
// - data out pin carries daisy output
module aprt_pin_routing (
    input wire pclk, // apb clock, 50 mhz
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    input wire [3:0] pstrb, // apb byte strobes
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error for unmapped or partial write
    // host-side pins, not timed to pclk
    input wire multi_pin_one, // general pin one
    input wire multi_pin_two, // general pin two
    input wire input_only_pin, // general input-only pin
    input wire serial_data_out_in, // level seen on the data out pin when used as input
    input wire serial_data_in, // data in pin
    input wire primary_bitclock_pin, // primary port bit clock pin
    input wire primary_sync_pin, // primary port frame sync pin
    // internal port signals, all flops
    output reg primary_bitclock, // internal primary bit clock
    output reg primary_sync, // internal primary frame sync
    output reg primary_data, // internal primary data input
    output reg secondary_bitclock, // internal secondary bit clock
    output reg secondary_sync, // internal secondary frame sync
    output reg secondary_data, // internal secondary data input one
    output reg secondary_data2, // internal secondary data input two
    output reg daisy_input, // internal daisy chain input
    output reg daisy_out_on_dout, // data out pin carries daisy output
    output reg secondary_follows_primary, // secondary uses primary settings
    output reg converter_powerdown, // converter power-down request
    output reg power_limiter, // power limiter request from pin one
    output reg pin_gain_feature // gain feature request from pin one
);

    // ***********************************************
    // registers and synchronisers
    // ***********************************************
    reg [7:0] iface_routing_two; // input accept, sync and clock sources
    reg [7:0] iface_routing_three; // data input sources
    reg [7:0] iface_routing_five; // power-down, limiter, gain feature
    reg [7:0] port_config_zero; // port off bits, gang, daisy
    reg [7:0] port_config_one; // daisy direction
    reg [7:0] soft_control; // software power-down

    // synchroniser vectors, one bit per pin
    reg [6:0] sync_a; // first stage, read only by second stage
    reg [6:0] sync_b; // second stage, safe for logic

    // pin order within the synchroniser vectors
    // status reads them in this order
    wire [6:0] pins_raw;
    assign pins_raw = {primary_sync_pin, primary_bitclock_pin, serial_data_in, serial_data_out_in,
                       input_only_pin, multi_pin_two, multi_pin_one};
    wire s_one = sync_b[0];
    wire s_two = sync_b[1];
    wire s_gpi = sync_b[2];
    wire s_dout = sync_b[3];
    wire s_din = sync_b[4];
    wire s_pbclk = sync_b[5];
    wire s_psync = sync_b[6];

    // ***********************************************
    // source selection function
    // ***********************************************
    // one decoder for every 3-bit source field; reserved codes give the inactive level
    // pin_dout is tied low where no data out code exists
    // one function keeps the five muxes alike
    function aprt_pick;
        input [2:0] code;
        input pin_one, pin_two, pin_gpi, pin_dout, prim;
        begin
            if (code == `APRT_SRC_PIN_ONE) begin
                aprt_pick = pin_one;
            end else if (code == `APRT_SRC_PIN_TWO) begin
                aprt_pick = pin_two;
            end else if (code == `APRT_SRC_INPUT_ONLY) begin
                aprt_pick = pin_gpi;
            end else if (code == `APRT_SRC_DATA_OUT_PIN) begin
                aprt_pick = pin_dout;
            end else if (code == `APRT_SRC_PRIMARY) begin
                aprt_pick = prim;
            end else begin
                aprt_pick = 1'b0;
            end
        end
    endfunction

    // every pin passes two flops before any logic sees it
    // pins are not timed to pclk; stage two hides metastability
    // nothing but sync_b reads sync_a
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    // ***********************************************
    // apb slave
    // ***********************************************

    // paddr[1:0] is ignored; one aligned word per register
    wire [9:0] word_index = paddr[11:2]; // register index
    wire setup_phase = psel && !penable; // answer is prepared here
    wire full_write = (pstrb[0] == 1'b1); // byte lane zero carries the register
    reg hit; // decoded index is mapped
    reg [7:0] read_value; // value of decoded register

    // address decode for reads and hit detection
    // a write to status is taken and changes nothing
    always @* begin
        hit = 1'b1;
        read_value = 8'h00;
        if (word_index == {2'h0, `APRT_IDX_ROUTING_TWO}) begin
            read_value = iface_routing_two;
        end else if (word_index == {2'h0, `APRT_IDX_ROUTING_THREE}) begin
            read_value = iface_routing_three;
        end else if (word_index == {2'h0, `APRT_IDX_ROUTING_FIVE}) begin
            read_value = iface_routing_five;
        end else if (word_index == {2'h0, `APRT_IDX_PORT_CONFIG_ZERO}) begin
            read_value = port_config_zero;
        end else if (word_index == {2'h0, `APRT_IDX_PORT_CONFIG_ONE}) begin
            read_value = port_config_one;
        end else if (word_index == {2'h0, `APRT_IDX_SOFT_CONTROL}) begin
            read_value = soft_control;
        end else if (word_index == {2'h0, `APRT_IDX_STATUS}) begin
            read_value = {1'b0, sync_b}; // live synchronised pin levels
        end else begin
            hit = 1'b0;
        end
    end

    // no wait state: ready rises in the first access cycle, so every access takes two cycles
    // prdata holds until the next setup
    // the error flag only ever pulses with ready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && (!hit || (pwrite && !full_write));
            if (setup_phase && !pwrite && hit) begin
                prdata <= {24'h00_0000, read_value};
            end else if (setup_phase) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // writes land at the completing edge; a partial write is refused so fields change only whole
    // upper byte lanes carry no register bits
    wire do_write = psel && penable && pready && pwrite && hit && full_write;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // primary on, secondary off, input accepted
            iface_routing_two <= `APRT_RST_ROUTING_TWO;
            iface_routing_three <= `APRT_RST_ROUTING_THREE;
            iface_routing_five <= `APRT_RST_ROUTING_FIVE;
            port_config_zero <= `APRT_RST_PORT_CONFIG_ZERO;
            port_config_one <= `APRT_RST_PORT_CONFIG_ONE;
            soft_control <= `APRT_RST_SOFT_CONTROL;
        end else if (do_write) begin
            // read-only reserved bits are masked; reserved codes are stored but decode inactive
            // read-back shows what software wrote
            if (word_index == {2'h0, `APRT_IDX_ROUTING_TWO}) begin
                iface_routing_two <= pwdata[7:0] & `APRT_WMASK_ROUTING_TWO;
            end else if (word_index == {2'h0, `APRT_IDX_ROUTING_THREE}) begin
                iface_routing_three <= pwdata[7:0] & `APRT_WMASK_ROUTING_THREE;
            end else if (word_index == {2'h0, `APRT_IDX_ROUTING_FIVE}) begin
                iface_routing_five <= pwdata[7:0] & `APRT_WMASK_ROUTING_FIVE;
            end else if (word_index == {2'h0, `APRT_IDX_PORT_CONFIG_ZERO}) begin
                port_config_zero <= pwdata[7:0] & `APRT_WMASK_PORT_CONFIG_ZERO;
            end else if (word_index == {2'h0, `APRT_IDX_PORT_CONFIG_ONE}) begin
                port_config_one <= pwdata[7:0] & `APRT_WMASK_PORT_CONFIG_ONE;
            end else if (word_index == {2'h0, `APRT_IDX_SOFT_CONTROL}) begin
                soft_control <= pwdata[7:0] & `APRT_WMASK_SOFT_CONTROL;
            end
        end
    end

    // ***********************************************
    // routing decode
    // ***********************************************
    // fields come from registers only,
    // so they are stable between writes
    wire [2:0] sync_src = iface_routing_two[`APRT_SYNC_SRC_HI:`APRT_SYNC_SRC_LO];
    wire [2:0] bclk_src = iface_routing_two[`APRT_BCLK_SRC_HI:`APRT_BCLK_SRC_LO];
    wire [2:0] in1_src = iface_routing_three[`APRT_IN1_SRC_HI:`APRT_IN1_SRC_LO];
    wire [2:0] in2_src = iface_routing_three[`APRT_IN2_SRC_HI:`APRT_IN2_SRC_LO];
    wire [1:0] pd_src = iface_routing_five[`APRT_PD_SRC_HI:`APRT_PD_SRC_LO];
    wire [1:0] daisy_mode = port_config_zero[`APRT_DAISY_EN_HI:`APRT_DAISY_EN_LO];
    wire [2:0] daisy_src = port_config_zero[`APRT_DAISY_IN_HI:`APRT_DAISY_IN_LO];

    // a daisy chain on one port takes the other port away
    // reserved daisy code three means no daisy
    // source zero on sync or clock turns secondary off
    wire primary_live = !port_config_zero[`APRT_BIT_PRIMARY_OFF]
        && (daisy_mode != `APRT_DAISY_SECONDARY);
    wire secondary_live = !port_config_zero[`APRT_BIT_SECONDARY_OFF]
        && (daisy_mode != `APRT_DAISY_PRIMARY)
        && (sync_src != `APRT_SRC_OFF) && (bclk_src != `APRT_SRC_OFF);
    // the data input also needs its accept bit
    wire primary_din_live = primary_live && iface_routing_two[`APRT_BIT_PRIMARY_INPUT_ACCEPT];
    // daisy runs on one port at a time
    wire daisy_live = (daisy_mode == `APRT_DAISY_PRIMARY) || (daisy_mode == `APRT_DAISY_SECONDARY);

    // power-down pin pick, two-bit field reuses the same pin codes
    // all four codes of this field are legal
    reg pd_pin;
    always @* begin
        case (pd_src)
            2'h1: pd_pin = s_one;
            2'h2: pd_pin = s_two;
            2'h3: pd_pin = s_gpi;
            default: pd_pin = 1'b0;
        endcase
    end

    // daisy input: code five is the data in pin, code four is reserved
    // code four must stay low in this field
    wire daisy_pick = (daisy_src == `APRT_SRC_DATA_OUT_PIN) ? 1'b0
        : aprt_pick(daisy_src, s_one, s_two, s_gpi, 1'b0, s_din);

    // ***********************************************
    // registered outputs
    // ***********************************************
    // all routing outputs are flops fed from synchronised pins or registers, so a routing change can only
    // switch on a clock edge; no combinational mux glitch reaches the internal clocks
    // latency: pin to output is three edges,
    // register write to output is one edge
    // limitation: a pin clock must stay well
    // below half of pclk or edges are lost
    // trade-off: latency for glitch-free switching
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_bitclock <= 1'b0;
            primary_sync <= 1'b0;
            primary_data <= 1'b0;
            secondary_bitclock <= 1'b0;
            secondary_sync <= 1'b0;
            secondary_data <= 1'b0;
            secondary_data2 <= 1'b0;
            daisy_input <= 1'b0;
            daisy_out_on_dout <= 1'b0;
            secondary_follows_primary <= 1'b0;
            converter_powerdown <= 1'b0;
            power_limiter <= 1'b0;
            pin_gain_feature <= 1'b0;
        end else begin
            // disabled port or source holds the inactive low level
            // primary port follows its own pins
            primary_bitclock <= primary_live ? s_pbclk : 1'b0;
            primary_sync <= primary_live ? s_psync : 1'b0;
            primary_data <= primary_din_live ? s_din : 1'b0;
            // secondary inputs go through their fields
            secondary_sync <= secondary_live
                ? aprt_pick(sync_src, s_one, s_two, s_gpi, 1'b0, s_psync) : 1'b0;
            secondary_bitclock <= secondary_live
                ? aprt_pick(bclk_src, s_one, s_two, s_gpi, 1'b0, s_pbclk) : 1'b0;
            secondary_data <= secondary_live
                ? aprt_pick(in1_src, s_one, s_two, s_gpi, s_dout, s_din) : 1'b0;
            secondary_data2 <= secondary_live
                ? aprt_pick(in2_src, s_one, s_two, s_gpi, s_dout, s_din) : 1'b0;
            // daisy, gang and power functions
            daisy_input <= daisy_live ? daisy_pick : 1'b0;
            daisy_out_on_dout <= daisy_live && port_config_one[`APRT_BIT_DAISY_DIR];
            secondary_follows_primary <= port_config_zero[`APRT_BIT_FOLLOWS_PRIMARY];
            converter_powerdown <= pd_pin || soft_control[`APRT_BIT_SOFT_POWERDOWN];
            power_limiter <= iface_routing_five[`APRT_BIT_POWER_LIMITER] && s_one;
            pin_gain_feature <= iface_routing_five[`APRT_BIT_GAIN_FEATURE] && s_one;
        end
    end

endmodule // aprt_pin_routing

/* File: verification/aprt_pin_routing_props.sv */
// assertion checker for the audio port pin routing block
`include "aprt_defs.vh"
module aprt_pin_routing_props (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic multi_pin_one, // general pin one
    input wire logic primary_bitclock_pin, // primary bit clock pin
    input wire logic primary_bitclock, // internal primary bit clock
    input wire logic primary_sync, // internal primary sync
    input wire logic primary_data, // internal primary data
    input wire logic secondary_bitclock, // internal secondary bit clock
    input wire logic secondary_sync, // internal secondary sync
    input wire logic secondary_data, // internal secondary data
    input wire logic secondary_follows_primary, // gang export
    input wire logic power_limiter, // limiter request
    input wire logic pin_gain_feature // gain feature request
);
    logic [7:0] cfg0_q; // shadow of the port config register
    // ************************************************
    // shadow register, accepted writes only
    // ************************************************
    // refused writes carry pslverr, so they never reach the shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0_q <= `APRT_RST_PORT_CONFIG_ZERO;
        end else if (psel && penable && pready && pwrite && !pslverr
                     && paddr[11:2] == `APRT_IDX_PORT_CONFIG_ZERO) begin
            cfg0_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ************************************************
    // properties
    // ************************************************
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    prim_off_quiet_a: assert property (cfg0_q[7] |=> !primary_bitclock && !primary_sync && !primary_data)
        else $error("primary port active while off");
    sec_off_quiet_a: assert property (cfg0_q[6] |=> !secondary_bitclock && !secondary_sync && !secondary_data)
        else $error("secondary port active while off");
    gang_export_a: assert property (secondary_follows_primary == $past(cfg0_q[5]))
        else $error("gang output differs from register");
    daisy_sec_a: assert property (cfg0_q[4:3] == 2'h1 |=> !secondary_bitclock && !secondary_sync)
        else $error("secondary active during primary daisy");
    gain_pin_a: assert property (pin_gain_feature |-> $past(multi_pin_one, 3))
        else $error("gain request without pin one");
    limiter_pin_a: assert property (power_limiter |-> $past(multi_pin_one, 3))
        else $error("limiter request without pin one");
    prim_clk_pin_a: assert property (primary_bitclock |-> $past(primary_bitclock_pin, 3))
        else $error("primary clock without its pin");
endmodule // aprt_pin_routing_props
bind aprt_pin_routing aprt_pin_routing_props u_props (.*);

/* File: verification/aprt_host_model.sv */
// host-side model: primary port pins and general pins
module aprt_host_model (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic run, // frames running
    input wire logic [4:0] lvl, // static levels {din,dout,gpi,pin2,pin1}
    output logic primary_bitclock_pin, // bit clock pin
    output logic primary_sync_pin, // frame sync pin
    output logic serial_data_in, // data in pin
    output logic multi_pin_one, // general pin one
    output logic multi_pin_two, // general pin two
    output logic input_only_pin, // input-only pin
    output logic serial_data_out_in // data out pin level
);
    logic [3:0] cnt; // frame position
    // frame counter, held at zero outside frames so the clock stands still
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
        end else begin
            cnt <= run ? cnt + 4'h1 : 4'h0;
        end
    end
    assign primary_bitclock_pin = run & cnt[0];
    assign primary_sync_pin = run & (cnt[3:1] == 3'h0);
    assign serial_data_in = run ? cnt[2] : lvl[4];
    assign {serial_data_out_in, input_only_pin, multi_pin_two, multi_pin_one} = lvl[3:0];
endmodule // aprt_host_model

/* File: verification/aprt_pin_routing_test.sv */
// self-checking testbench for the audio port pin routing block
`include "aprt_defs.vh"
module aprt_pin_routing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [4:0] lvl = 5'h00; // static pin levels
    logic [2:0] bclk_h = 3'h0, sync_h = 3'h0; // primary pin history
    wire [31:0] prdata;
    wire pready, pslverr, multi_pin_one, multi_pin_two, input_only_pin, serial_data_out_in, serial_data_in;
    wire primary_bitclock_pin, primary_sync_pin, primary_bitclock, primary_sync, primary_data;
    wire secondary_bitclock, secondary_sync, secondary_data, secondary_data2, daisy_input;
    wire daisy_out_on_dout, secondary_follows_primary, converter_powerdown, power_limiter, pin_gain_feature;
    int n_fail = 0, n_compared = 0, cyc = 0;
    localparam logic [11:0] A2 = `APRT_IDX_ROUTING_TWO * 4, A3 = `APRT_IDX_ROUTING_THREE * 4;
    localparam logic [11:0] A5 = `APRT_IDX_ROUTING_FIVE * 4, A0 = `APRT_IDX_PORT_CONFIG_ZERO * 4;
    localparam logic [11:0] A1 = `APRT_IDX_PORT_CONFIG_ONE * 4, AS = `APRT_IDX_SOFT_CONTROL * 4;
    aprt_pin_routing u_dut (.*);
    aprt_host_model u_host (.pclk(pclk), .presetn(presetn), .run(run), .lvl(lvl),
        .primary_bitclock_pin(primary_bitclock_pin), .primary_sync_pin(primary_sync_pin),
        .serial_data_in(serial_data_in), .multi_pin_one(multi_pin_one), .multi_pin_two(multi_pin_two),
        .input_only_pin(input_only_pin), .serial_data_out_in(serial_data_out_in));
    // ************************************************
    // clock, timeout, shared tasks
    // ************************************************
    initial forever #10 pclk = ~pclk;
    // bit 2 is the pin level that the outputs show at the next negedge
    always @(posedge pclk) begin
        bclk_h <= {bclk_h[1:0], primary_bitclock_pin};
        sync_h <= {sync_h[1:0], primary_sync_pin};
    end
    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report;
        end
    end
    task final_report;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
             output logic [7:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, 4'h1, r, e);
    endtask
    task rd_chk(input logic [11:0] a, input logic [7:0] x, input logic xe);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, 4'h0, r, e);
        check(r, x);
        check(e, xe);
    endtask
    task settle;
        repeat (5) @(posedge pclk); // 3 edges pin latency plus margin
    endtask
    // codes 1..5 pick a level, the rest are off
    function automatic logic pick(input logic [2:0] c, input logic [4:0] v);
        pick = (c >= 3'h1 && c <= 3'h5) ? v[c - 3'h1] : 1'b0;
    endfunction
    // ************************************************
    // scenarios
    // ************************************************
    task t_regs;
        logic [7:0] r;
        logic e;
        rd_chk(A2, `APRT_RST_ROUTING_TWO, 0);
        rd_chk(A3, `APRT_RST_ROUTING_THREE, 0);
        rd_chk(A5, `APRT_RST_ROUTING_FIVE, 0);
        rd_chk(A0, `APRT_RST_PORT_CONFIG_ZERO, 0);
        rd_chk(A1, `APRT_RST_PORT_CONFIG_ONE, 0);
        rd_chk(12'h0fc, 8'h00, 1);
        wr(A2, 8'h52);
        rd_chk(A2, 8'h52, 0);
        wr(A2, 8'h80);
        apb(1'b1, A5, 8'h05, 4'h2, r, e);
        check(e, 1'b1);
        rd_chk(A5, 8'h00, 0);
    endtask
    task t_route(input logic [4:0] v);
        logic [2:0] c;
        wr(A0, 8'h00);
        for (int i = 0; i < 6; i++) begin
            c = i[2:0];
            wr(A3, 8'h00);
            if (c != 3'h4) begin
                wr(A2, {1'b1, c, c, 1'b0});
                settle;
                check(secondary_bitclock, pick(c, {2'b00, v[2:0]}));
                check(secondary_sync, pick(c, {2'b00, v[2:0]}));
            end
            wr(A2, 8'h92);
            wr(A3, {c, c, 2'b00});
            settle;
            check(secondary_data, pick(c, v));
            check(secondary_data2, pick(c, v));
        end
        wr(A2, 8'hda);
        settle;
        run <= 1;
        repeat (16) begin
            @(negedge pclk);
            check(secondary_bitclock, bclk_h[2]);
            check(secondary_sync, sync_h[2]);
            check(primary_bitclock, bclk_h[2]);
            check(primary_sync, sync_h[2]);
        end
        @(posedge pclk);
        run <= 0;
    endtask
    task t_daisy(input logic [4:0] v);
        logic [2:0] c;
        wr(A2, 8'h92);
        wr(A1, 8'h08);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            if (c == 3'h4 || c > 3'h5) continue;
            wr(A0, {3'b000, 2'h1, c});
            settle;
            check(daisy_input, pick(c, {v[4], 1'b0, v[2:0]}));
            check(secondary_bitclock, 1'b0);
            check(daisy_out_on_dout, 1'b1);
        end
        wr(A0, 8'h11);
        settle;
        check(primary_data, 1'b0);
        wr(A0, 8'h10);
        settle;
        check(daisy_input, 1'b0);
        wr(A0, 8'h01);
        settle;
        check(daisy_out_on_dout, 1'b0);
        wr(A1, 8'h00);
    endtask
    task t_power(input logic [4:0] v);
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = {1'b0, i[1:0]};
            wr(A5, {4'h0, c[1:0], 2'b11});
            wr(AS, {7'h00, i[2]});
            settle;
            check(converter_powerdown, i[2] | pick(c, v));
            check(power_limiter, v[0]);
            check(pin_gain_feature, v[0]);
        end
        wr(A5, 8'h00);
        wr(AS, 8'h00);
        settle;
        check(power_limiter | pin_gain_feature | converter_powerdown, 1'b0);
    endtask
    task t_primary;
        lvl <= 5'h10;
        wr(A0, 8'h00);
        wr(A2, 8'h00);
        settle;
        check(primary_data, 1'b0);
        wr(A2, 8'h80);
        settle;
        check(primary_data, 1'b1);
        wr(A0, 8'ha0);
        settle;
        check(primary_data, 1'b0);
        check(secondary_follows_primary, 1'b1);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_regs;
        for (int i = 0; i < 2; i++) begin
            lvl <= i ? 5'h0a : 5'h15;
            t_route(i ? 5'h0a : 5'h15);
            t_daisy(i ? 5'h0a : 5'h15);
            t_power(i ? 5'h0a : 5'h15);
        end
        t_primary;
        final_report;
    end
endmodule // aprt_pin_routing_test
